// file: hw/pfsm_top.sv
// Pin function selection logic for the port pins.
`timescale 1ns/1ps
`include "pfsm_defs.svh"
// Summary of operation
// RULE_01: Oscillate with buffer and feedback resistor on.
// RULE_02: Oscillate, buffer on, feedback resistor off.
// RULE_03: Xin stopped: buffer off, pins may be ports.
// RULE_04: Stop mode turns buffer and resistor off.
// RULE_05: Pulse waveform on secondary timer pin.
// RULE_06: Programmable waveform when output control set.
// RULE_07: One-shot or wait one-shot waveform routing.
// RULE_08: Channel A output compare selection.
// RULE_09: Channels B to D output compare.
// RULE_10: Input capture regardless of output disable.
// RULE_11: Channel A pin as OFF_A trigger.
// RULE_12: Channel B outputs OFF_A waveform.
// RULE_13: Channels B to D output PWM waveform.
// RULE_14: Shared pin becomes CMOS open-drain clock.
// RULE_15: Pull-up follows pull-up control bit.
// RULE_16: High drive follows drive-select bit.
// RULE_17: Open-drain bit ignored in low-voltage mode.
// RULE_18: Low-voltage mode swaps Schmitt for CMOS.
// RULE_19: CMOS threshold from two threshold registers.
// RULE_20: Low-voltage on serial and interrupt pins.
// RULE_21: Pins are inputs after reset.
// RULE_22: Unmatched settings fall back to port.
module pfsm_top
  import pfsm_pkg::*;
(
  input  wire logic                    i_clk,                  // System clock, 25 MHz.
  input  wire logic                    i_rstn,                 // Synchronous reset, active low.
  input  wire pfsm_osc_s               i_osc,                  // Oscillator control bits.
  input  wire logic                    i_osc_in_pin,           // Oscillator input pin level.
  input  wire logic                    i_osc_out_pin,          // Oscillator output pin level.
  input  wire logic                    i_port_out_osc_in,      // Port data for oscillator input pin.
  input  wire logic                    i_port_out_osc_out,     // Port data for oscillator output pin.
  input  wire logic                    i_timer_out_ctrl,       // Secondary timer output control.
  input  wire logic                    i_timer_mode_hi,        // Timer mode field high bit.
  input  wire logic                    i_timer_mode_lo,        // Timer mode field low bit.
  input  wire logic [3:0]              i_tmr_wave,             // Pulse, programmable, one-shot, wait.
  input  wire pfsm_trc_s               i_trc,                  // Multi-channel timer settings.
  input  wire logic [3:0]              i_trc_cmp_wave,         // Compare waveforms A to D.
  input  wire logic [3:0]              i_trc_pwm_wave,         // PWM waveforms A to D.
  input  wire logic                    i_trc_off_a_wave,        // OFF_A waveform.
  input  wire logic [3:0]              i_trc_pin,              // Timer channel pin levels A to D.
  input  wire logic                    i_dir_shared_rx_pin,    // Direction of shared serial pin.
  input  wire logic                    i_sensor_unit_enable,   // Sensor unit enable.
  input  wire logic                    i_serial_low_voltage_en,// Serial low-voltage mode.
  input  wire logic                    i_irq_low_voltage_en,   // Interrupt low-voltage mode.
  input  wire logic [2:0]              i_serial_mode,          // Serial mode field.
  input  wire logic [2:0]              i_rx_pin_sel,           // Serial receive pin select.
  input  wire logic                    i_i2c_select,           // I2C select bit.
  input  wire logic                    i_serial_open_drain,    // Serial open-drain bit.
  input  wire logic                    i_serial_clk_out,       // Serial clock drive value.
  input  wire logic                    i_shared_rx_pin,        // Shared serial pin level.
  input  wire logic                    i_pullup_group_bit,     // Pull-up control for group four.
  input  wire logic                    i_drive_strength_bit,   // Drive select for group four.
  input  wire logic [7:0]              i_threshold_reg_zero,   // CMOS threshold setting zero.
  input  wire logic [7:0]              i_threshold_reg_one,    // CMOS threshold setting one.
  output logic                         o_osc_buffer_on,        // Oscillator buffer enable.
  output logic                         o_feedback_on,          // Feedback resistor enable.
  output logic [1:0]                   o_osc_pin_oe,           // Oscillator pin output enables.
  output logic [1:0]                   o_osc_pin_out,          // Oscillator pin drive values.
  output logic [1:0]                   o_osc_pin_in,           // Oscillator pin port input values.
  output logic                         o_secondary_timer_output, // Secondary timer pin drive.
  output logic [3:0]                   o_trc_pin_oe,           // Timer channel output enables.
  output logic [3:0]                   o_trc_pin_out,          // Timer channel drive values.
  output logic [3:0]                   o_trc_capture,          // Capture input values A to D.
  output logic                         o_multi_timer_trigger_in, // OFF_A trigger input.
  output logic [`PFSM_CH_N*3-1:0]      o_trc_func,             // Channel functions, packed enum.
  output logic                         o_serial_two_bus_clock, // Shared pin clock input value.
  output logic                         o_shared_cmos_in,       // Shared pin uses CMOS input.
  output logic                         o_shared_oe,            // Shared pin output enable.
  output logic                         o_shared_out,           // Shared pin drive value.
  output logic                         o_pullup_en,            // Pull-up attached.
  output logic                         o_high_drive,           // High drive strength.
  output logic                         o_serial_od_active,     // Serial output is open-drain.
  output logic [3:0]                   o_lv_cmos_en,           // CMOS input: uart0, uart2, irq, shared.
  output logic [7:0]                   o_threshold_zero,       // Applied threshold zero.
  output logic [7:0]                   o_threshold_one         // Applied threshold one.
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Pin levels cross in from outside, so each goes through two stages.
  logic [6:0] pin_meta_reg, pin_meta_next;
  logic [6:0] pin_sync_reg, pin_sync_next;
  always_comb begin
    pin_meta_next = {i_osc_in_pin, i_osc_out_pin, i_trc_pin, i_shared_rx_pin};
    pin_sync_next = pin_meta_reg;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pin_meta_reg <= 7'h00;
      pin_sync_reg <= 7'h00;
    end else begin
      pin_meta_reg <= pin_meta_next;
      pin_sync_reg <= pin_sync_next;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator pin pair
  // ----------------------------------------------------------------
  logic       buf_next;
  logic       fb_next;
  logic [1:0] osc_oe_next;
  logic [1:0] osc_out_next;
  logic [1:0] osc_in_next;
  // Stop mode has priority: it kills the resistor even if feedback_off is clear.
  always_comb begin
    buf_next     = 1'b0;
    fb_next      = 1'b0;
    osc_oe_next  = 2'h0;
    osc_out_next = 2'h0;
    osc_in_next  = 2'h0;
    if (i_osc.osc_pin_select) begin
      if (i_osc.stop_all) begin
        buf_next = 1'b0; // RULE_04
        fb_next  = 1'b0; // RULE_04
      end else begin
        buf_next = !i_osc.xin_stop; // RULE_01 RULE_02 RULE_03
        fb_next  = !i_osc.feedback_off; // RULE_01 RULE_02 RULE_03
      end
    end else begin
      // Port mode on the pair; the buffer stays off.
      osc_oe_next  = {i_osc.dir_osc_in_pin, i_osc.dir_osc_out_pin}; // RULE_03 RULE_22
      osc_out_next = {i_port_out_osc_in, i_port_out_osc_out};
      osc_in_next  = pin_sync_reg[6:5];
    end
  end

  // ----------------------------------------------------------------
  // Secondary timer output
  // ----------------------------------------------------------------
  logic tmr_next;
  always_comb begin
    tmr_next = 1'b0;
    case ({i_timer_out_ctrl, i_timer_mode_hi, i_timer_mode_lo})
      {1'b0, `PFSM_TMOD_PULSE}:   tmr_next = i_tmr_wave[0]; // RULE_05
      {1'b1, `PFSM_TMOD_PULSE}:   tmr_next = i_tmr_wave[1]; // RULE_06
      {1'b0, `PFSM_TMOD_ONESHOT}: tmr_next = i_tmr_wave[2]; // RULE_07
      {1'b0, `PFSM_TMOD_WAIT}:    tmr_next = i_tmr_wave[3]; // RULE_07
      default:                    tmr_next = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Multi-channel timer pins
  // ----------------------------------------------------------------
  pfsm_ch_e   ch_func [`PFSM_CH_N];
  logic [3:0] trc_oe_next, trc_out_next, trc_cap_next;
  logic       trig_next;
  logic [`PFSM_CH_N*3-1:0] func_next;
  genvar g;
  generate
    for (g = 0; g < `PFSM_CH_N; g++) begin : g_ch
      // Channel A has no PWM select bit; treat it as zero.
      logic psel;
      logic cmp_sel;
      assign psel    = (g == 0) ? 1'b0 : i_trc.pwm_sel[g];
      assign cmp_sel = i_trc.io_sel_1[g] | i_trc.io_sel_0[g];
      always_comb begin
        ch_func[g] = PFSM_CH_PORT; // RULE_22
        if (!i_trc.off_a) begin
          if (g == 0) begin
            if ((!i_trc.out_disable[0] && {i_trc.trigger_edge_hi, i_trc.trigger_edge_lo} == `PFSM_TCEG_RISE) ||
                (i_trc.out_disable[0] && i_trc.trigger_edge_hi)) begin
              ch_func[g] = PFSM_CH_TRIGGER; // RULE_11
            end
          end else if (g == 1 && !i_trc.out_disable[1]) begin
            ch_func[g] = PFSM_CH_OFF_A; // RULE_12
          end
        end else if (psel) begin
          if (!i_trc.out_disable[g]) begin
            ch_func[g] = PFSM_CH_PWM; // RULE_13
          end
        end else if (i_trc.io_sel_2[g]) begin
          ch_func[g] = PFSM_CH_CAPTURE; // RULE_10
        end else if (cmp_sel && !i_trc.out_disable[g]) begin
          ch_func[g] = PFSM_CH_COMPARE; // RULE_08 RULE_09
        end
      end
      assign trc_oe_next[g]  = (ch_func[g] == PFSM_CH_COMPARE) || (ch_func[g] == PFSM_CH_PWM) ||
                               (ch_func[g] == PFSM_CH_OFF_A);
      assign trc_out_next[g] = (ch_func[g] == PFSM_CH_COMPARE) ? i_trc_cmp_wave[g] :
                               (ch_func[g] == PFSM_CH_PWM)     ? i_trc_pwm_wave[g] :
                               (ch_func[g] == PFSM_CH_OFF_A)    ? i_trc_off_a_wave : 1'b0;
      assign trc_cap_next[g] = (ch_func[g] == PFSM_CH_CAPTURE) ? pin_sync_reg[g + 1] : 1'b0;
      assign func_next[g*3 +: 3] = ch_func[g];
    end
  endgenerate
  assign trig_next = (ch_func[0] == PFSM_CH_TRIGGER) ? pin_sync_reg[1] : 1'b0; // RULE_11

  // ----------------------------------------------------------------
  // Shared serial pin and low-voltage mode
  // ----------------------------------------------------------------
  logic       i2c_clk_mode;
  logic       sh_cmos_next, sh_oe_next, sh_out_next, sh_clk_next, od_next;
  logic [3:0] lv_next;
  always_comb begin
    i2c_clk_mode = !i_dir_shared_rx_pin && !i_sensor_unit_enable && !i_irq_low_voltage_en &&
                   (i_rx_pin_sel == `PFSM_RXSEL_P45) && (i_serial_mode == `PFSM_SMD_I2C) && i_i2c_select;
    // Low-voltage mode forces open drain, so the open-drain bit is ignored then.
    od_next      = i_serial_low_voltage_en | i_serial_open_drain; // RULE_17
    sh_cmos_next = i_serial_low_voltage_en && !i_dir_shared_rx_pin; // RULE_14 RULE_18
    // Open-drain drive: enable only while pulling low.
    sh_oe_next   = i2c_clk_mode && (od_next || i_serial_low_voltage_en) ? !i_serial_clk_out :
                   i2c_clk_mode ? 1'b1 : i_dir_shared_rx_pin; // RULE_14 RULE_22
    sh_out_next  = i2c_clk_mode ? (od_next ? 1'b0 : i_serial_clk_out) : 1'b0;
    sh_clk_next  = i2c_clk_mode ? pin_sync_reg[0] : 1'b1;
    // UART0, UART2 and interrupt pins each gain CMOS input in low-voltage mode.
    lv_next      = {sh_cmos_next, i_irq_low_voltage_en, i_serial_low_voltage_en,
                    i_serial_low_voltage_en}; // RULE_18 RULE_20
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Reset clears all output enables, so every pin starts as an input.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_osc_buffer_on          <= 1'b0;
      o_feedback_on            <= 1'b0;
      o_osc_pin_oe             <= 2'h0; // RULE_21
      o_osc_pin_out            <= 2'h0;
      o_osc_pin_in             <= 2'h0;
      o_secondary_timer_output <= 1'b0;
      o_trc_pin_oe             <= 4'h0; // RULE_21
      o_trc_pin_out            <= 4'h0;
      o_trc_capture            <= 4'h0;
      o_multi_timer_trigger_in <= 1'b0;
      o_trc_func               <= 12'h000;
      o_serial_two_bus_clock   <= 1'b1;
      o_shared_cmos_in         <= 1'b0;
      o_shared_oe              <= 1'b0; // RULE_21
      o_shared_out             <= 1'b0;
      o_pullup_en              <= 1'b0;
      o_high_drive             <= 1'b0;
      o_serial_od_active       <= 1'b0;
      o_lv_cmos_en             <= 4'h0;
      o_threshold_zero         <= `PFSM_VLT_RST;
      o_threshold_one          <= `PFSM_VLT_RST;
    end else begin
      o_osc_buffer_on          <= buf_next;
      o_feedback_on            <= fb_next;
      o_osc_pin_oe             <= osc_oe_next;
      o_osc_pin_out            <= osc_out_next;
      o_osc_pin_in             <= osc_in_next;
      o_secondary_timer_output <= tmr_next;
      o_trc_pin_oe             <= trc_oe_next;
      o_trc_pin_out            <= trc_out_next;
      o_trc_capture            <= trc_cap_next;
      o_multi_timer_trigger_in <= trig_next;
      o_trc_func               <= func_next;
      o_serial_two_bus_clock   <= sh_clk_next;
      o_shared_cmos_in         <= sh_cmos_next;
      o_shared_oe              <= sh_oe_next;
      o_shared_out             <= sh_out_next;
      o_pullup_en              <= i_pullup_group_bit; // RULE_15
      o_high_drive             <= i_drive_strength_bit; // RULE_16
      o_serial_od_active       <= od_next;
      o_lv_cmos_en             <= lv_next;
      o_threshold_zero         <= i_threshold_reg_zero; // RULE_19
      o_threshold_one          <= i_threshold_reg_one; // RULE_19
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_stop_kills_osc: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_04
    i_osc.stop_all && i_osc.osc_pin_select |=> !o_osc_buffer_on && !o_feedback_on)
    else $error("Stop mode left oscillator on.");
  a_osc_run_buf: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_01
    !i_osc.xin_stop && !i_osc.stop_all && i_osc.osc_pin_select |=> o_osc_buffer_on)
    else $error("Oscillator buffer not on.");
  a_fb_follows: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_02
    !i_osc.stop_all && i_osc.osc_pin_select |=> o_feedback_on == !$past(i_osc.feedback_off))
    else $error("Feedback resistor mismatch.");
  // Reset leaves on a clock edge, so antecedents that hold at rest also ask for reset high.
  a_port_dir_osc: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_03
    i_rstn && !i_osc.osc_pin_select |=> !o_osc_buffer_on && o_osc_pin_oe[1] == $past(i_osc.dir_osc_in_pin))
    else $error("Oscillator port direction wrong.");
  a_tmr_pulse: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_05
    !i_timer_out_ctrl && !i_timer_mode_hi && i_timer_mode_lo |=> o_secondary_timer_output == $past(i_tmr_wave[0]))
    else $error("Pulse waveform not routed.");
  a_tmr_prog: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_06
    i_timer_out_ctrl && !i_timer_mode_hi && i_timer_mode_lo |=> o_secondary_timer_output == $past(i_tmr_wave[1]))
    else $error("Programmable waveform not routed.");
  a_cap_no_oe: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_10
    i_trc.off_a && i_trc.io_sel_2[0] |=> !o_trc_pin_oe[0])
    else $error("Capture pin driven.");
  a_od_ignored: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_17
    i_serial_low_voltage_en |=> o_serial_od_active)
    else $error("Low-voltage mode not open-drain.");
  a_off_a_b: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE_12
    i_rstn && !i_trc.off_a && !i_trc.out_disable[1] |=>
      o_trc_pin_oe[1] && o_trc_pin_out[1] == $past(i_trc_off_a_wave))
    else $error("OFF_A waveform missing on channel B.");

endmodule // pfsm_top

// file: shared/pfsm_defs.svh
// Constant definitions for the port function select mux.
`ifndef PFSM_DEFS_SVH
`define PFSM_DEFS_SVH
`define PFSM_TMOD_PULSE   2'h1
`define PFSM_TMOD_ONESHOT 2'h2
`define PFSM_TMOD_WAIT    2'h3
`define PFSM_TCEG_RISE    2'h1
`define PFSM_SMD_I2C      3'h2
`define PFSM_RXSEL_P45    3'h3
`define PFSM_VLT_W        8
`define PFSM_VLT_RST      8'h00
`define PFSM_CH_N         4
`endif

// file: shared/pfsm_pkg.sv
// Types shared by the port function select mux.
package pfsm_pkg;
  typedef struct packed {
    logic       xin_stop;
    logic       stop_all;
    logic       feedback_off;
    logic       osc_pin_select;
    logic       dir_osc_in_pin;
    logic       dir_osc_out_pin;
  } pfsm_osc_s;
  typedef struct packed {
    logic       off_a;
    logic [3:0] out_disable;
    logic [3:0] pwm_sel;
    logic [3:0] io_sel_2;
    logic [3:0] io_sel_1;
    logic [3:0] io_sel_0;
    logic       trigger_edge_hi;
    logic       trigger_edge_lo;
  } pfsm_trc_s;
  typedef enum logic [2:0] {
    PFSM_CH_PORT    = 3'b000,
    PFSM_CH_COMPARE = 3'b001,
    PFSM_CH_CAPTURE = 3'b010,
    PFSM_CH_TRIGGER = 3'b011,
    PFSM_CH_PWM     = 3'b100,
    PFSM_CH_OFF_A    = 3'b101
  } pfsm_ch_e;
endpackage

// file: verif/pfsm_pins.sv
// Board-side pin model that closes the loop from the mux's drivers back to its pin inputs.
`timescale 1ns/1ps
module pfsm_pins (
  input  wire logic       i_clk,         // Board model clock.
  input  wire logic [1:0] i_osc_oe,      // Oscillator pin output enables.
  input  wire logic [1:0] i_osc_out,     // Oscillator pin drive values.
  input  wire logic [3:0] i_trc_oe,      // Timer channel output enables.
  input  wire logic [3:0] i_trc_out,     // Timer channel drive values.
  input  wire logic       i_shared_oe,   // Shared serial pin output enable.
  input  wire logic       i_shared_out,  // Shared serial pin drive value.
  output logic            o_osc_in_pin,  // Oscillator input pin level.
  output logic            o_osc_out_pin, // Oscillator output pin level.
  output logic [3:0]      o_trc_pin,     // Timer channel pin levels.
  output logic            o_shared_pin   // Shared serial pin level.
);
  // -------------------------------------------------------------------
  // Released pins
  // -------------------------------------------------------------------
  // A floating pin toggles every cycle, so a stale value is never mistaken for a driven one.
  logic float_q = 1'b0;
  always @(posedge i_clk) float_q <= ~float_q;
  // Driven pins show the drive value; released pins show the toggling pattern.
  assign o_osc_in_pin  = i_osc_oe[1] ? i_osc_out[1] : float_q;
  assign o_osc_out_pin = i_osc_oe[0] ? i_osc_out[0] : float_q;
  assign o_trc_pin     = (i_trc_oe & i_trc_out) | (~i_trc_oe & {4{float_q}});
  // The shared pin is open drain, so the bus pull-up holds it high when released.
  assign o_shared_pin  = (i_shared_oe & ~i_shared_out) ? 1'b0 : 1'b1;
endmodule // pfsm_pins

// file: verif/test_port_function_select_mux.sv
// Self-checking testbench for the port function select mux.
`timescale 1ns/1ps
module test_port_function_select_mux
  import pfsm_pkg::*;
;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_osc_in_pin, i_osc_out_pin, i_shared_rx_pin;
  logic [3:0] i_trc_pin;
  pfsm_osc_s osc;
  pfsm_trc_s trc;
  logic [1:0] port_d, tmode, osc_oe, osc_out, osc_in;
  logic tctrl, pwm2w, sdir, sens, slv, ilv, i2c, sod, sclk, pu, drv;
  logic [3:0] twave, cmpw, pwmw, trc_oe, trc_out, trc_cap, lv;
  logic [2:0] smode, rxsel;
  logic [7:0] th0, th1, th0_o, th1_o;
  logic [11:0] func;
  logic buf_on, fb_on, tmr_o, trig, bclk, scmos, soe, sout, pu_o, hd_o, od_o;
  int n_errors = 0, n_tests = 0;
  always #20 i_clk = ~i_clk;
  // -------------------------------------------------------------------
  // Design and board model
  // -------------------------------------------------------------------
  pfsm_top pfsm_top_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_osc(osc), .i_osc_in_pin(i_osc_in_pin),
    .i_osc_out_pin(i_osc_out_pin), .i_port_out_osc_in(port_d[1]), .i_port_out_osc_out(port_d[0]),
    .i_timer_out_ctrl(tctrl), .i_timer_mode_hi(tmode[1]), .i_timer_mode_lo(tmode[0]), .i_tmr_wave(twave),
    .i_trc(trc), .i_trc_cmp_wave(cmpw), .i_trc_pwm_wave(pwmw), .i_trc_off_a_wave(pwm2w), .i_trc_pin(i_trc_pin),
    .i_dir_shared_rx_pin(sdir), .i_sensor_unit_enable(sens), .i_serial_low_voltage_en(slv),
    .i_irq_low_voltage_en(ilv), .i_serial_mode(smode), .i_rx_pin_sel(rxsel), .i_i2c_select(i2c),
    .i_serial_open_drain(sod), .i_serial_clk_out(sclk), .i_shared_rx_pin(i_shared_rx_pin),
    .i_pullup_group_bit(pu), .i_drive_strength_bit(drv), .i_threshold_reg_zero(th0), .i_threshold_reg_one(th1),
    .o_osc_buffer_on(buf_on), .o_feedback_on(fb_on), .o_osc_pin_oe(osc_oe), .o_osc_pin_out(osc_out),
    .o_osc_pin_in(osc_in), .o_secondary_timer_output(tmr_o), .o_trc_pin_oe(trc_oe), .o_trc_pin_out(trc_out),
    .o_trc_capture(trc_cap), .o_multi_timer_trigger_in(trig), .o_trc_func(func), .o_serial_two_bus_clock(bclk),
    .o_shared_cmos_in(scmos), .o_shared_oe(soe), .o_shared_out(sout), .o_pullup_en(pu_o), .o_high_drive(hd_o),
    .o_serial_od_active(od_o), .o_lv_cmos_en(lv), .o_threshold_zero(th0_o), .o_threshold_one(th1_o));
  pfsm_pins pfsm_pins_i (.i_clk(i_clk), .i_osc_oe(osc_oe), .i_osc_out(osc_out), .i_trc_oe(trc_oe),
    .i_trc_out(trc_out), .i_shared_oe(soe), .i_shared_out(sout), .o_osc_in_pin(i_osc_in_pin),
    .o_osc_out_pin(i_osc_out_pin), .o_trc_pin(i_trc_pin), .o_shared_pin(i_shared_rx_pin));
  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Lets settings pass the synchronisers and output registers before sampling.
  task automatic settle();
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  // The oscillator pin directions request output during reset, yet every pin must stay an input.
  task automatic t_reset();
    repeat (2) @(posedge i_clk);
    #1;
    chk("osc_oe_rst", 12'h000, {10'h000, osc_oe});
    chk("trc_oe_rst", 12'h000, {8'h00, trc_oe});
    chk("shared_oe_rst", 12'h001, {10'h000, soe, bclk});
  endtask
  // Walks the oscillator control table: {xin_stop,stop_all,fb_off,sel} then {buffer,resistor}.
  task automatic t_osc();
    logic [5:0] rows [5];
    rows = '{6'h07, 6'h0E, 6'h25, 6'h2C, 6'h34};
    foreach (rows[k]) begin
      @(posedge i_clk);
      osc <= '{rows[k][5], rows[k][4], rows[k][3], rows[k][2], 1'b1, 1'b1};
      settle();
      chk("osc_buf_fb", {10'h000, rows[k][1:0]}, {10'h000, buf_on, fb_on});
    end
    // Stopped clock with port selection: in pin drives, out pin reads the board.
    @(posedge i_clk);
    osc <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    port_d <= 2'h3;
    settle();
    chk("osc_port_oe", 12'h002, {10'h000, osc_oe});
    chk("osc_port_lb", 12'h003, {10'h000, osc_out[1], osc_in[1]});
  endtask
  // Each timer mode must pick its own waveform and no other.
  task automatic t_timer();
    logic [2:0] sel [4];
    sel = '{3'h1, 3'h5, 3'h2, 3'h3};
    foreach (sel[k]) begin
      @(posedge i_clk);
      {tctrl, tmode} <= sel[k];
      twave <= 4'h1 << k;
      settle();
      chk("tmr_sel", 12'h001, {11'h000, tmr_o});
      @(posedge i_clk);
      twave <= ~(4'h1 << k);
      settle();
      chk("tmr_other", 12'h000, {11'h000, tmr_o});
    end
  endtask
  // Multi-channel timer pin functions; the fields are {off_a,dis,pwm,io2,io1,io0,edge}.
  task automatic t_trc();
    @(posedge i_clk);
    trc <= '{1'b0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 1'b1};
    pwm2w <= 1'b1;
    settle();
    chk("trc_trig_off_a", {6'h00, PFSM_CH_OFF_A, PFSM_CH_TRIGGER}, {6'h00, func[5:0]});
    chk("trc_off_a_pin", 12'h003, {10'h000, trc_oe[1], trc_out[1]});
    @(posedge i_clk);
    trc <= '{1'b0, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 1'b1, 1'b0};
    settle();
    chk("trc_trig_hi", {9'h000, PFSM_CH_TRIGGER}, {9'h000, func[2:0]});
    // A released pin toggles each cycle; three stages later the trigger shows the inverse.
    chk("trc_trig_pin", {11'h000, ~pfsm_pins_i.float_q}, {11'h000, trig});
    @(posedge i_clk);
    trc <= '{1'b1, 4'h0, 4'hE, 4'h0, 4'h0, 4'hF, 1'b0, 1'b0};
    cmpw <= 4'h1;
    pwmw <= 4'hA;
    settle();
    chk("trc_cmp_pwm", {PFSM_CH_PWM, PFSM_CH_PWM, PFSM_CH_PWM, PFSM_CH_COMPARE}, func);
    chk("trc_cmp_pwm_out", 12'h0FB, {4'h0, trc_oe, trc_out});
    @(posedge i_clk);
    trc <= '{1'b1, 4'h0, 4'h0, 4'h0, 4'hF, 4'h0, 1'b0, 1'b0};
    settle();
    chk("trc_cmp_1x", {4{PFSM_CH_COMPARE}}, func);
    @(posedge i_clk);
    trc <= '{1'b1, 4'hF, 4'h0, 4'hF, 4'h0, 4'h0, 1'b0, 1'b0};
    settle();
    chk("trc_capture", {4{PFSM_CH_CAPTURE}}, func);
    chk("trc_cap_oe", 12'h000, {8'h00, trc_oe});
    chk("trc_cap_val", {8'h00, {4{~pfsm_pins_i.float_q}}}, {8'h00, trc_cap});
  endtask
  // Shared serial pin, open drain, low-voltage inputs, thresholds, pull-up and drive.
  task automatic t_serial();
    @(posedge i_clk);
    {sdir, sens, slv, ilv, i2c, sclk} <= 6'h0A;
    smode <= 3'h2;
    rxsel <= 3'h3;
    {pu, drv, sod} <= 3'h6;
    th0 <= 8'h5A;
    th1 <= 8'hA5;
    settle();
    chk("shared_i2c", 12'h006, {9'h000, scmos, soe, sout});
    chk("bus_clk_low", 12'h000, {11'h000, bclk});
    chk("od_ignored", 12'h001, {11'h000, od_o});
    chk("pu_drive", 12'h003, {10'h000, pu_o, hd_o});
    chk("thresholds", 12'h5A5, {th0_o[7:4], th1_o});
    @(posedge i_clk);
    {slv, ilv, sod, pu, drv} <= 5'h0C;
    settle();
    chk("od_set", 12'h001, {11'h000, od_o});
    chk("lv_irq", 12'h004, {8'h00, lv});
    chk("pu_off", 12'h000, {10'h000, pu_o, hd_o});
    chk("bus_clk_idle", 12'h001, {11'h000, bclk});
    @(posedge i_clk);
    sod <= 1'b0;
    settle();
    chk("od_clear", 12'h000, {11'h000, od_o});
  endtask
  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    osc = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    trc = '0;
    {port_d, tmode, tctrl, pwm2w, twave, cmpw, pwmw} = '0;
    {sdir, sens, slv, ilv, i2c, sod, sclk, pu, drv, smode, rxsel, th0, th1} = '0;
    t_reset();
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_osc();
    t_timer();
    t_trc();
    t_serial();
    tally_and_finish();
  end
endmodule // test_port_function_select_mux
